// file: common/conv_ctrl_pkg.sv
// constants, field layout and state codes for the converter control block
// assumes a single 40 MHz core clock and synchronous serial pin samples
package conv_ctrl_pkg;
  // register offsets
  localparam logic [7:0] REG_VOUT_LOW   = 8'h00;
  localparam logic [7:0] REG_VOUT_HIGH  = 8'h01;
  localparam logic [7:0] REG_APPLY      = 8'h02;
  localparam logic [7:0] REG_ILIM       = 8'h03;
  localparam logic [7:0] REG_CTL_ONE    = 8'h04;
  localparam logic [7:0] REG_CTL_TWO    = 8'h05;
  // field widths and positions
  localparam int         VOUT_W         = 11;
  localparam int         VOUT_LOW_W     = 3;
  localparam int         ILIM_W         = 7;
  localparam int         APPLY_GO_BIT   = 0;
  localparam int         APPLY_PGD_BIT  = 1;
  localparam int         CONVERTER_CONTROL_ONE_ON_BIT    = 7;
  localparam int         CONVERTER_CONTROL_ONE_RETRY_BIT = 6;
  localparam int         CONVERTER_CONTROL_ONE_DISCH_BIT = 5;
  localparam int         CONVERTER_CONTROL_ONE_FPWM_BIT  = 4;
  localparam int         CONVERTER_CONTROL_ONE_RATE_LSB  = 2;
  localparam int         CONVERTER_CONTROL_TWO_DROOP_LSB = 6;
  localparam int         CONVERTER_CONTROL_TWO_SS_LSB    = 4;
  localparam logic [7:0] CONVERTER_CONTROL_ONE_MASK      = 8'hFC;
  localparam logic [7:0] CONVERTER_CONTROL_TWO_MASK      = 8'hF0;
  // reset values and droop threshold
  localparam logic [10:0] VOUT_RESET    = 11'h1F4;
  localparam logic [6:0]  ILIM_RESET    = 7'h46;
  localparam logic [7:0]  CONVERTER_CONTROL_ONE_RESET    = 8'hF0;
  localparam logic [7:0]  CONVERTER_CONTROL_TWO_RESET    = 8'h70;
  localparam logic [10:0] DROOP_MIN     = 11'h1F4;
  // bus address per pin band
  localparam logic [6:0]  BUS_ADDR_BAND [4] = '{7'h60, 7'h62, 7'h64, 7'h66};
  // timing
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          RAMP_STEP_NS  = 10000;
  localparam int          PG_DELAY_NS   = 100000;
  localparam logic [8:0]  RAMP_STEP_CYC = 9'(RAMP_STEP_NS / CLK_PERIOD_NS);
  localparam logic [11:0] PG_DELAY_CYC  = 12'(PG_DELAY_NS / CLK_PERIOD_NS);
  // serial slave states
  typedef enum logic [3:0]
  {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h2,
    ST_REG       = 4'h3,
    ST_REG_ACK   = 4'h4,
    ST_WDATA     = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA     = 4'h7,
    ST_RDATA_ACK = 4'h8,
    ST_RDATA_NXT = 4'h9
  } slave_state_t;
endpackage

// file: hdl/vout_ramp_timer.sv
// output reference ramp and power-good rise delay
// assumes target and go are held stable by the register bank
`timescale 1ns/100ps
`default_nettype none
module vout_ramp_timer
  import conv_ctrl_pkg::*;
(
  input  wire logic                            clk_i,
  input  wire logic                            reset_i,
  input  wire logic                            ce_i,
  input  wire logic                            go_i,
  input  wire logic [conv_ctrl_pkg::VOUT_W-1:0] target_i,
  input  wire logic                            pg_raw_i,
  input  wire logic                            pg_delay_i,
  output logic      [conv_ctrl_pkg::VOUT_W-1:0] ref_o,
  output logic                                 done_o,
  output logic                                 pg_o
);
  logic [8:0]        tick;
  logic [8:0]        next_tick;
  logic [VOUT_W-1:0] next_ref;
  logic              next_done;
  logic [11:0]       pg_cnt;
  logic [11:0]       next_pg_cnt;
  logic              next_pg;

  always_comb
  begin
    next_tick   = 9'h000;
    next_ref    = ref_o;
    next_done   = 1'b0;
    next_pg_cnt = 12'h000;
    next_pg     = 1'b0;
    if (go_i && ref_o != target_i)
    begin
      // one code step each 10 us gives 1 mV/us
      if (tick == RAMP_STEP_CYC - 9'h001) // [RQ4]
      begin
        next_ref = (ref_o < target_i) ? ref_o + 11'h001 : ref_o - 11'h001; // [RQ5]
      end
      else
      begin
        next_tick = tick + 9'h001;
      end
    end
    else if (go_i && !done_o)
    begin
      next_done = 1'b1; // [RQ5]
    end
    if (pg_raw_i)
    begin
      if (!pg_delay_i || pg_cnt == PG_DELAY_CYC - 12'h001)
      begin
        next_pg     = 1'b1; // [RQ8]
        next_pg_cnt = pg_cnt;
      end
      else
      begin
        next_pg_cnt = pg_cnt + 12'h001; // [RQ8]
        next_pg     = pg_o;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      tick   <= 9'h000;
      ref_o  <= VOUT_RESET; // [RQ3]
      done_o <= 1'b0;
      pg_cnt <= 12'h000;
      pg_o   <= 1'b0;
    end
    else if (ce_i)
    begin
      tick   <= next_tick;
      ref_o  <= next_ref;
      done_o <= next_done;
      pg_cnt <= next_pg_cnt;
      pg_o   <= next_pg;
    end
  end
endmodule // vout_ramp_timer
`default_nettype wire

// file: hdl/converter_control_registers.sv
// serial slave and control register bank of the buck-boost converter
// assumes scl/sda samples are synchronous to CORE_CLK_I; address band from comparators
// Operation
// (RQ1) bus address chosen from address pin band
// (RQ2) voltage code is high byte then low bits
// (RQ3) code times 10 mV, reset code 500
// (RQ4) reference ramps at 1 mV per microsecond
// (RQ5) go bit starts ramp, self-clears when done
// (RQ6) host writes voltage before setting go
// (RQ7) discharge path on while go is set
// (RQ8) power-good rise delayed 100 us if selected
// (RQ9) current limit 7 bits, 50 mA steps, reset 70
// (RQ10) host steps limit slowly while limiting
// (RQ11) enable pin low forces off; bit 7 controls
// (RQ12) on/off bit clear keeps registers intact
// (RQ13) bit 6 selects hiccup or latch-off faults
// (RQ14) bit 5 enables shutdown output discharge
// (RQ15) bit 4 selects forced or automatic modulation
// (RQ16) bits 3:2 select switching frequency
// (RQ17) bits 7:6 of second register select droop
// (RQ18) droop applied only at 5 V or above
// (RQ19) bits 5:4 of second register soft-start time
// (RQ20) write is start, address, register, data
// (RQ21) data byte commits at end of LSB
// (RQ22) unused bits read zero, writes ignored
`timescale 1ns/100ps
`default_nettype none
module converter_control_registers
  import conv_ctrl_pkg::*;
(
  input  wire logic                            CORE_CLK_I,
  input  wire logic                            RESET_I,
  input  wire logic                            CE_I,
  input  wire logic                            SCL_I,
  input  wire logic                            SDA_I,
  input  wire logic                            EN_PIN_I,
  input  wire logic [1:0]                      ADDR_BAND_I,
  input  wire logic                            POWER_GOOD_RAW_I,
  output logic                                 SDA_O,
  output logic                                 SDA_OE_O,
  output logic                                 CONVERTER_ON_O,
  output logic                                 FAULT_RETRY_O,
  output logic                                 SHUTDOWN_DISCHARGE_O,
  output logic                                 RAMP_DISCHARGE_O,
  output logic                                 FORCED_PWM_O,
  output logic      [1:0]                      SWITCH_RATE_O,
  output logic      [1:0]                      DROOP_SELECT_O,
  output logic      [1:0]                      SOFT_START_SELECT_O,
  output logic      [conv_ctrl_pkg::ILIM_W-1:0] CURRENT_LIMIT_O,
  output logic      [conv_ctrl_pkg::VOUT_W-1:0] VREF_CODE_O,
  output logic                                 POWER_GOOD_FLAG_O
);
  // serial slave state
  slave_state_t           state;
  slave_state_t           next_state;
  logic [3:0]             cnt;
  logic [3:0]             next_cnt;
  logic [7:0]             shift;
  logic [7:0]             next_shift;
  logic [7:0]             ptr;
  logic [7:0]             next_ptr;
  logic                   rw;
  logic                   next_rw;
  logic                   scl_prev;
  logic                   sda_prev;
  logic [6:0]             bus_addr;
  logic                   wr_stb;
  logic                   start_seen;
  logic                   stop_seen;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   next_sda_oe;
  // register bank
  logic [VOUT_LOW_W-1:0]  vout_low;
  logic [VOUT_LOW_W-1:0]  next_vout_low;
  logic [7:0]             vout_high;
  logic [7:0]             next_vout_high;
  logic                   go;
  logic                   next_go;
  logic                   pg_delay;
  logic                   next_pg_delay;
  logic [ILIM_W-1:0]      ilim;
  logic [ILIM_W-1:0]      next_ilim;
  logic [7:0]             ctl_one;
  logic [7:0]             next_ctl_one;
  logic [7:0]             ctl_two;
  logic [7:0]             next_ctl_two;
  logic [VOUT_W-1:0]      target;
  logic                   ramp_done;

  function automatic logic [7:0] read_reg(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      REG_VOUT_LOW:  r = {5'h00, vout_low}; // [RQ22]
      REG_VOUT_HIGH: r = vout_high;
      REG_APPLY:     r = {6'h00, pg_delay, go}; // [RQ5]
      REG_ILIM:      r = {1'b0, ilim}; // [RQ22]
      REG_CTL_ONE:   r = ctl_one & CONVERTER_CONTROL_ONE_MASK;
      REG_CTL_TWO:   r = ctl_two & CONVERTER_CONTROL_TWO_MASK;
      default:       r = 8'h00;
    endcase
    return r;
  endfunction

  assign target     = {vout_high, vout_low}; // [RQ2]
  assign start_seen = scl_prev && SCL_I && sda_prev && !SDA_I;
  assign stop_seen  = scl_prev && SCL_I && !sda_prev && SDA_I;
  assign scl_rise   = !scl_prev && SCL_I;
  assign scl_fall   = scl_prev && !SCL_I;

  // serial slave
  always_comb
  begin
    next_state  = state;
    next_cnt    = cnt;
    next_shift  = shift;
    next_ptr    = ptr;
    next_rw     = rw;
    next_sda_oe = SDA_OE_O;
    wr_stb      = 1'b0;
    if (!EN_PIN_I)
    begin
      next_state  = ST_IDLE; // [RQ11]
      next_sda_oe = 1'b0;
    end
    else if (start_seen)
    begin
      next_state  = ST_ADDR; // [RQ20]
      next_cnt    = 4'h0;
      next_sda_oe = 1'b0;
    end
    else if (stop_seen)
    begin
      next_state  = ST_IDLE;
      next_sda_oe = 1'b0;
    end
    else
    begin
      case (state)
        ST_ADDR, ST_REG, ST_WDATA:
        begin
          if (scl_rise)
          begin
            next_shift = {shift[6:0], SDA_I};
            next_cnt   = cnt + 4'h1;
          end
          else if (scl_fall && cnt == 4'h8)
          begin
            next_sda_oe = 1'b1;
            if (state == ST_ADDR)
            begin
              next_rw    = shift[0];
              next_state = ST_ADDR_ACK;
              if (shift[7:1] != bus_addr) // [RQ1]
              begin
                next_sda_oe = 1'b0;
                next_state  = ST_IDLE;
              end
            end
            else if (state == ST_REG)
            begin
              next_ptr   = shift;
              next_state = ST_REG_ACK;
            end
            else
            begin
              wr_stb     = 1'b1; // [RQ21]
              next_state = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            next_cnt    = 4'h0;
            next_sda_oe = 1'b0;
            next_state  = (state == ST_ADDR_ACK) ? ST_REG : ST_WDATA;
            if (state == ST_WDATA_ACK)
            begin
              next_ptr = ptr + 8'h01;
            end
            if (state == ST_ADDR_ACK && rw)
            begin
              next_shift  = read_reg(ptr);
              next_sda_oe = !next_shift[7];
              next_state  = ST_RDATA;
            end
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (cnt == 4'h7)
            begin
              next_sda_oe = 1'b0;
              next_state  = ST_RDATA_ACK;
            end
            else
            begin
              next_cnt    = cnt + 4'h1;
              next_shift  = {shift[6:0], 1'b0};
              next_sda_oe = !shift[6];
            end
          end
        end
        ST_RDATA_ACK:
        begin
          if (scl_rise)
          begin
            next_state = SDA_I ? ST_IDLE : ST_RDATA_NXT;
          end
        end
        ST_RDATA_NXT:
        begin
          if (scl_fall)
          begin
            next_ptr    = ptr + 8'h01;
            next_shift  = read_reg(ptr + 8'h01);
            next_sda_oe = !next_shift[7];
            next_cnt    = 4'h0;
            next_state  = ST_RDATA;
          end
        end
        default:
        begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      state    <= ST_IDLE;
      cnt      <= 4'h0;
      shift    <= 8'h00;
      ptr      <= 8'h00;
      rw       <= 1'b0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      bus_addr <= 7'h00;
      SDA_OE_O <= 1'b0;
      SDA_O    <= 1'b1;
    end
    else if (CE_I)
    begin
      state    <= next_state;
      cnt      <= next_cnt;
      shift    <= next_shift;
      ptr      <= next_ptr;
      rw       <= next_rw;
      scl_prev <= SCL_I;
      sda_prev <= SDA_I;
      bus_addr <= BUS_ADDR_BAND[ADDR_BAND_I]; // [RQ1]
      SDA_OE_O <= next_sda_oe;
      SDA_O    <= !next_sda_oe;
    end
  end

  // register bank
  always_comb
  begin
    next_vout_low  = vout_low;
    next_vout_high = vout_high;
    next_go        = go;
    next_pg_delay  = pg_delay;
    next_ilim      = ilim;
    next_ctl_one   = ctl_one;
    next_ctl_two   = ctl_two;
    if (ramp_done)
    begin
      next_go = 1'b0; // [RQ5]
    end
    if (wr_stb)
    begin
      case (ptr)
        REG_VOUT_LOW:  next_vout_low  = shift[VOUT_LOW_W-1:0]; // [RQ22]
        REG_VOUT_HIGH: next_vout_high = shift;
        REG_APPLY:
        begin
          next_go       = shift[APPLY_GO_BIT]; // [RQ5]
          next_pg_delay = shift[APPLY_PGD_BIT]; // [RQ8]
        end
        REG_ILIM:      next_ilim      = shift[ILIM_W-1:0]; // [RQ9] [RQ22]
        REG_CTL_ONE:   next_ctl_one   = shift & CONVERTER_CONTROL_ONE_MASK;
        REG_CTL_TWO:   next_ctl_two   = shift & CONVERTER_CONTROL_TWO_MASK;
        default:       next_go        = next_go;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      vout_low  <= VOUT_RESET[VOUT_LOW_W-1:0]; // [RQ3]
      vout_high <= VOUT_RESET[VOUT_W-1:VOUT_LOW_W];
      go        <= 1'b0;
      pg_delay  <= 1'b0;
      ilim      <= ILIM_RESET; // [RQ9]
      ctl_one   <= CONVERTER_CONTROL_ONE_RESET;
      ctl_two   <= CONVERTER_CONTROL_TWO_RESET;
    end
    else if (CE_I)
    begin
      vout_low  <= next_vout_low;
      vout_high <= next_vout_high;
      go        <= next_go;
      pg_delay  <= next_pg_delay;
      ilim      <= next_ilim;
      ctl_one   <= next_ctl_one; // [RQ12]
      ctl_two   <= next_ctl_two;
    end
  end

  vout_ramp_timer ramp_unit
  (
    .clk_i      (CORE_CLK_I),
    .reset_i    (RESET_I),
    .ce_i       (CE_I),
    .go_i       (go),
    .target_i   (target),
    .pg_raw_i   (POWER_GOOD_RAW_I),
    .pg_delay_i (pg_delay),
    .ref_o      (VREF_CODE_O),
    .done_o     (ramp_done),
    .pg_o       (POWER_GOOD_FLAG_O)
  );

  // converter control outputs
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      CONVERTER_ON_O       <= 1'b0;
      FAULT_RETRY_O        <= 1'b1;
      SHUTDOWN_DISCHARGE_O <= 1'b1;
      RAMP_DISCHARGE_O     <= 1'b0;
      FORCED_PWM_O         <= 1'b1;
      SWITCH_RATE_O        <= 2'h0;
      DROOP_SELECT_O       <= 2'h0;
      SOFT_START_SELECT_O  <= 2'h3;
      CURRENT_LIMIT_O      <= ILIM_RESET;
    end
    else if (CE_I)
    begin
      CONVERTER_ON_O       <= EN_PIN_I && ctl_one[CONVERTER_CONTROL_ONE_ON_BIT]; // [RQ11]
      FAULT_RETRY_O        <= ctl_one[CONVERTER_CONTROL_ONE_RETRY_BIT]; // [RQ13]
      SHUTDOWN_DISCHARGE_O <= ctl_one[CONVERTER_CONTROL_ONE_DISCH_BIT]; // [RQ14]
      RAMP_DISCHARGE_O     <= go; // [RQ7]
      FORCED_PWM_O         <= ctl_one[CONVERTER_CONTROL_ONE_FPWM_BIT]; // [RQ15]
      SWITCH_RATE_O        <= ctl_one[CONVERTER_CONTROL_ONE_RATE_LSB +: 2]; // [RQ16]
      DROOP_SELECT_O       <= (target >= DROOP_MIN) ? ctl_two[CONVERTER_CONTROL_TWO_DROOP_LSB +: 2] : 2'h0; // [RQ17] [RQ18]
      SOFT_START_SELECT_O  <= ctl_two[CONVERTER_CONTROL_TWO_SS_LSB +: 2]; // [RQ19]
      CURRENT_LIMIT_O      <= ilim; // [RQ9]
    end
  end
endmodule // converter_control_registers
`default_nettype wire

// file: tb/conv_ctrl_host.sv
// behavioural serial bus master for the converter control block
// assumes open-drain wiring with pull-ups resolved by the testbench
`timescale 1ns/100ps
`default_nettype none
module conv_ctrl_host
(
  input  wire logic clk_i,
  input  wire logic sda_line_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // change lines just after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  task automatic put_bit(input logic b);
    sda_o = b;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    scl_o = 1'b0;
  endtask

  // line released, sampled mid high phase
  task automatic get_bit(output logic b);
    sda_o = 1'b1;
    tick(4);
    scl_o = 1'b1;
    tick(2);
    b = sda_line_i;
    tick(2);
    scl_o = 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic nb;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(nb);
    ack = !nb;
  endtask

  task automatic start;
    sda_o = 1'b1;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    sda_o = 1'b0;
    tick(4);
    scl_o = 1'b0;
  endtask

  task automatic stop;
    sda_o = 1'b0;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    sda_o = 1'b1;
    tick(4);
  endtask

  // start, address+write, register byte, data byte
  task automatic write_reg(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start();
    put_byte({a, 1'b0}, k0);
    put_byte(r, k1);
    put_byte(d, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask

  task automatic read_reg(input logic [6:0] a, input logic [7:0] r, output logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start();
    put_byte({a, 1'b0}, k0);
    put_byte(r, k1);
    start();
    put_byte({a, 1'b1}, k2);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
    stop();
    ok = k0 & k1 & k2;
  endtask
endmodule // conv_ctrl_host
`default_nettype wire

// file: tb/conv_ctrl_sva.sv
// port-level checker for the converter control block
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module conv_ctrl_sva
(
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        SCL_I,
  input  wire logic        EN_PIN_I,
  input  wire logic        POWER_GOOD_RAW_I,
  input  wire logic        SDA_OE_O,
  input  wire logic        CONVERTER_ON_O,
  input  wire logic        FAULT_RETRY_O,
  input  wire logic        SHUTDOWN_DISCHARGE_O,
  input  wire logic        RAMP_DISCHARGE_O,
  input  wire logic        FORCED_PWM_O,
  input  wire logic [1:0]  SWITCH_RATE_O,
  input  wire logic [1:0]  SOFT_START_SELECT_O,
  input  wire logic [6:0]  CURRENT_LIMIT_O,
  input  wire logic [10:0] VREF_CODE_O,
  input  wire logic        POWER_GOOD_FLAG_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);

  logic [10:0] last_vref, next_last_vref;
  logic [9:0]  gap, next_gap;
  logic        stepped, next_stepped, chg;
  logic [12:0] hi_cnt, next_hi_cnt;

  // step spacing and raw power-good run length
  always_comb
  begin
    chg = VREF_CODE_O != last_vref;
    next_last_vref = VREF_CODE_O;
    next_gap = (gap == 10'h3FF) ? gap : gap + 10'h001;
    next_stepped = stepped;
    if (!RAMP_DISCHARGE_O)
    begin
      next_gap = 10'h000;
      next_stepped = 1'b0;
    end
    else if (chg)
    begin
      next_gap = 10'h001;
      next_stepped = 1'b1;
    end
    next_hi_cnt = !POWER_GOOD_RAW_I ? 13'h0000 : (hi_cnt == 13'h1FFF) ? hi_cnt : hi_cnt + 13'h0001;
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    last_vref <= next_last_vref;
    gap <= RESET_I ? 10'h000 : next_gap;
    stepped <= RESET_I ? 1'b0 : next_stepped;
    hi_cnt <= RESET_I ? 13'h0000 : next_hi_cnt;
  end

  chk_on_needs_pin: assert property (CONVERTER_ON_O |-> $past(EN_PIN_I))
    else $error("converter on without enable pin");
  chk_bus_quiet_off: assert property (!EN_PIN_I [*2] |=> !SDA_OE_O)
    else $error("data line driven while disabled");
  chk_oe_at_fall: assert property
    (EN_PIN_I && $past(EN_PIN_I) && ($rose(SDA_OE_O) || $fell(SDA_OE_O)) |-> $past(SCL_I, 2) && !$past(SCL_I))
    else $error("data line drive changed away from clock fall");
  chk_cfg_on_low: assert property
    ($changed({FAULT_RETRY_O, SHUTDOWN_DISCHARGE_O, FORCED_PWM_O, SWITCH_RATE_O, SOFT_START_SELECT_O,
               CURRENT_LIMIT_O}) |-> !SCL_I)
    else $error("control output changed outside data commit");
  chk_vref_unit: assert property
    (chg && RAMP_DISCHARGE_O |-> VREF_CODE_O == last_vref + 11'h001 || VREF_CODE_O + 11'h001 == last_vref)
    else $error("reference moved by more than one step");
  chk_vref_gap: assert property (chg && stepped |-> gap == 10'h190)
    else $error("reference step spacing wrong");
  chk_pg_drop: assert property (!POWER_GOOD_RAW_I |=> !POWER_GOOD_FLAG_O)
    else $error("power good held after raw drop");
  chk_pg_rise: assert property
    ($rose(POWER_GOOD_FLAG_O) |-> hi_cnt inside {[13'h0001:13'h0003], [13'h0F9E:13'h0FA3]})
    else $error("power good rose at wrong time");
endmodule // conv_ctrl_sva

bind converter_control_registers conv_ctrl_sva conv_ctrl_sva_i
(
  .CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I), .SCL_I(SCL_I), .EN_PIN_I(EN_PIN_I),
  .POWER_GOOD_RAW_I(POWER_GOOD_RAW_I), .SDA_OE_O(SDA_OE_O), .CONVERTER_ON_O(CONVERTER_ON_O),
  .FAULT_RETRY_O(FAULT_RETRY_O), .SHUTDOWN_DISCHARGE_O(SHUTDOWN_DISCHARGE_O), .RAMP_DISCHARGE_O(RAMP_DISCHARGE_O),
  .FORCED_PWM_O(FORCED_PWM_O), .SWITCH_RATE_O(SWITCH_RATE_O), .SOFT_START_SELECT_O(SOFT_START_SELECT_O),
  .CURRENT_LIMIT_O(CURRENT_LIMIT_O), .VREF_CODE_O(VREF_CODE_O), .POWER_GOOD_FLAG_O(POWER_GOOD_FLAG_O)
);
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the converter control block
// assumes the host model and checker files are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench;
  import conv_ctrl_pkg::*;
  logic       clk, rst, en, raw, ce, ok, sda_oe, sda_d, on, retry, sdis, rdis, fpwm, pg;
  logic [1:0] band, rate, droop, ss;
  logic [6:0] ilim, dev;
  logic [10:0] vref;
  logic [7:0] q;
  wire logic  scl, sda_m, sda_line;
  int         error_cnt, n_tests;
  logic [7:0] rst_tab [6] = '{8'h04, 8'h3E, 8'h00, 8'h46, 8'hF0, 8'h70};

  // device pulls low through its data output while enabled, pull-up otherwise
  assign sda_line = sda_m & (sda_oe ? sda_d : 1'b1);

  converter_control_registers converter_control_registers_i
  (
    .CORE_CLK_I(clk), .RESET_I(rst), .CE_I(ce), .SCL_I(scl), .SDA_I(sda_line), .EN_PIN_I(en),
    .ADDR_BAND_I(band), .POWER_GOOD_RAW_I(raw), .SDA_O(sda_d), .SDA_OE_O(sda_oe), .CONVERTER_ON_O(on),
    .FAULT_RETRY_O(retry), .SHUTDOWN_DISCHARGE_O(sdis), .RAMP_DISCHARGE_O(rdis), .FORCED_PWM_O(fpwm),
    .SWITCH_RATE_O(rate), .DROOP_SELECT_O(droop), .SOFT_START_SELECT_O(ss), .CURRENT_LIMIT_O(ilim),
    .VREF_CODE_O(vref), .POWER_GOOD_FLAG_O(pg)
  );
  conv_ctrl_host host_i (.clk_i(clk), .sda_line_i(sda_line), .scl_o(scl), .sda_o(sda_m));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    host_i.write_reg(dev, r, d, ok);
    `CHK(ok, 1'b1)
  endtask

  task automatic rd(input logic [7:0] r, input logic [7:0] e);
    host_i.read_reg(dev, r, q, ok);
    `CHK(ok, 1'b1)
    `CHK(q, e)
  endtask

  // poll the go bit under a bounded count
  task automatic wait_go;
    for (int i = 0; i < 10; i++)
    begin
      host_i.read_reg(dev, 8'h02, q, ok);
      if (q[0] === 1'b0) break;
    end
    `CHK(q[0], 1'b0)
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    close_out();
  end

  initial
  begin
    {rst, en, raw, ce, band, dev} = {1'b1, 1'b1, 1'b0, 1'b1, 2'h0, 7'h60};
    repeat (8) @(posedge clk);
    #2 rst = 1'b0;
    host_i.tick(4);
    `CHK({on, retry, sdis, fpwm, rate, ss, droop, ilim, vref}, {10'h3CD, 7'h46, 11'h1F4})
    for (int i = 0; i < 6; i++) rd(8'(i), rst_tab[i]);
    $display("reset values done");
    for (int b = 0; b < 4; b++)
    begin
      band = 2'(b);
      dev = 7'h60 + 7'(2 * ((b + 1) % 4));
      host_i.tick(3);
      host_i.read_reg(dev, 8'h05, q, ok);
      `CHK(ok, 1'b0)
      dev = 7'h60 + 7'(2 * b);
      rd(8'h05, 8'h70);
    end
    rd(8'h06, 8'h00);
    $display("address bands done");
    wr(8'h03, 8'hFF);
    `CHK(ilim, 7'h7F)
    rd(8'h03, 8'h7F);
    for (int v = 8'h46; v <= 8'h48; v++) wr(8'h03, 8'(v));
    `CHK(ilim, 7'h48)
    wr(8'h04, 8'h00);
    `CHK({on, retry, sdis, fpwm, rate}, 6'h00)
    rd(8'h03, 8'h48);
    wr(8'h04, 8'hFF);
    `CHK({on, retry, sdis, fpwm, rate}, 6'h3F)
    rd(8'h04, 8'hFC);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h05, {2'(i), 2'(3 - i), 4'hF});
      `CHK({droop, ss}, {2'(i), 2'(3 - i)})
    end
    $display("control fields done");
    wr(8'h00, 8'h05);
    host_i.tick(20);
    `CHK(vref, 11'h1F4)
    wr(8'h02, 8'h01);
    `CHK(rdis, 1'b1)
    wait_go();
    `CHK({vref, rdis}, {11'h1F5, 1'b0})
    wr(8'h00, 8'h03);
    `CHK(droop, 2'h0)
    wr(8'h02, 8'h01);
    wait_go();
    `CHK(vref, 11'h1F3)
    wr(8'h00, 8'hFC);
    `CHK(droop, 2'h3)
    rd(8'h00, 8'h04);
    $display("voltage ramp done");
    raw = 1'b1;
    host_i.tick(3);
    `CHK(pg, 1'b1)
    raw = 1'b0;
    wr(8'h02, 8'h02);
    raw = 1'b1;
    host_i.tick(3990);
    `CHK(pg, 1'b0)
    host_i.tick(20);
    `CHK(pg, 1'b1)
    rd(8'h02, 8'h02);
    $display("power good done");
    en = 1'b0;
    host_i.tick(3);
    `CHK(on, 1'b0)
    host_i.write_reg(dev, 8'h04, 8'h00, ok);
    `CHK(ok, 1'b0)
    en = 1'b1;
    host_i.tick(3);
    rd(8'h04, 8'hFC);
    `CHK(on, 1'b1)
    $display("enable pin done");
    ce = 1'b0;
    host_i.write_reg(dev, 8'h04, 8'h00, ok);
    `CHK(ok, 1'b0)
    ce = 1'b1;
    host_i.tick(3);
    `CHK(on, 1'b1)
    rd(8'h04, 8'hFC);
    rst = 1'b1;
    host_i.tick(2);
    rst = 1'b0;
    host_i.tick(4);
    `CHK({rate, ss, ilim, vref, pg}, {2'h0, 2'h3, 7'h46, 11'h1F4, 1'b1})
    rd(8'h03, 8'h46);
    rd(8'h02, 8'h00);
    $display("clock enable and mid-run reset done");
    close_out();
  end
endmodule // testbench
`default_nettype wire
